/* cvt_pkg.sv */
package cvt_pkg;
    // ------------------------------------------------------------
    // clock and counters
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 40;
    localparam int CNT_W = 32;
    localparam int NS_PER_MS = 1000000;
    localparam int NS_PER_S10 = 100000000;

    // ------------------------------------------------------------
    // times as printed, then cycle counts
    // ------------------------------------------------------------
    localparam int DWELL_MAX_MS = 250;
    localparam int BLOCK_MIN_S10 = 15;
    localparam int DWELL_MAX_CYC = (DWELL_MAX_MS * NS_PER_MS) / CLK_PERIOD_NS;
    localparam int BLOCK_MIN_CYC = (BLOCK_MIN_S10 * NS_PER_S10 + CLK_PERIOD_NS - 1)
                                   / CLK_PERIOD_NS;
    localparam int MATCH_MS = 32;
    localparam int CREDIT_MS = 32;
    localparam int CREDIT_GAP_MS = 32;
    localparam int FAULT_BASE_MS = 32;
    localparam int GATE_OPEN_MS = 200;
    localparam int MATCH_CYC = (MATCH_MS * NS_PER_MS) / CLK_PERIOD_NS;
    localparam int CREDIT_CYC = (CREDIT_MS * NS_PER_MS) / CLK_PERIOD_NS;
    localparam int CREDIT_GAP_CYC = (CREDIT_GAP_MS * NS_PER_MS) / CLK_PERIOD_NS;
    localparam int FAULT_BASE_CYC = (FAULT_BASE_MS * NS_PER_MS) / CLK_PERIOD_NS;
    localparam int GATE_OPEN_CYC = (GATE_OPEN_MS * NS_PER_MS) / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // input vector layout and field widths
    // ------------------------------------------------------------
    localparam int IN_W = 8;
    localparam int IN_COIL = 0;
    localparam int IN_UPPER = 1;
    localparam int IN_LOWER = 2;
    localparam int IN_BLOCK = 3;
    localparam int IN_POL = 4;
    localparam int IN_REF = 5;
    localparam int IN_SEL = 6;
    localparam int FAULT_SEL_W = 2;
    localparam int MATCH_W = 3;
    localparam int QUEUE_W = 4;
    localparam logic [MATCH_W-1:0] MATCH_MAX = 3'h7;
    localparam logic [QUEUE_W-1:0] QUEUE_MAX = 4'hF;

    typedef enum logic [1:0] {
        OPT_IDLE,
        OPT_UPPER,
        OPT_BOTH,
        OPT_LOWER
    } cvt_opt_t;
endpackage

/* cvt_pulse_if.sv */
`timescale 1ns/1ps
interface cvt_pulse_if;
    import cvt_pkg::*;
    logic start;
    logic [CNT_W-1:0] high_len;
    logic [CNT_W-1:0] low_len;
    logic pulse;
    logic busy;
    modport gen (input start, input high_len, input low_len, output pulse, output busy);
    modport user (output start, output high_len, output low_len, input pulse, input busy);
endinterface

/* cvt_pulse_gen.sv */
`timescale 1ns/1ps
module cvt_pulse_gen (
    input wire logic core_clk,
    input wire logic rst,
    cvt_pulse_if.gen pif
);
    import cvt_pkg::*;

    typedef struct packed {
        logic busy;
        logic high;
        logic [CNT_W-1:0] cnt;
    } cvt_pg_t;

    cvt_pg_t s_q;
    cvt_pg_t s_d;

    // ------------------------------------------------------------
    // high phase then optional low phase; start ignored while busy
    // ------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        if (!s_q.busy) begin
            if (pif.start) begin
                s_d.busy = 1'b1;
                s_d.high = 1'b1;
                s_d.cnt = (pif.high_len == '0) ? '0 : pif.high_len - 1'b1;
            end
        end else if (s_q.cnt != '0) begin
            s_d.cnt = s_q.cnt - 1'b1;
        end else if (s_q.high && pif.low_len != '0) begin
            s_d.high = 1'b0;
            s_d.cnt = pif.low_len - 1'b1;
        end else begin
            s_d.busy = 1'b0;
            s_d.high = 1'b0;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign pif.pulse = s_q.busy & s_q.high;
    assign pif.busy = s_q.busy;
endmodule

/* cvt_coin_validator.sv */
`timescale 1ns/1ps
module cvt_coin_validator #(
    parameter int DWELL_CYC = cvt_pkg::DWELL_MAX_CYC,
    parameter int BLOCK_CYC = cvt_pkg::BLOCK_MIN_CYC,
    parameter int MATCH_LEN = cvt_pkg::MATCH_CYC,
    parameter int CREDIT_LEN = cvt_pkg::CREDIT_CYC,
    parameter int CREDIT_GAP = cvt_pkg::CREDIT_GAP_CYC,
    parameter int FAULT_BASE = cvt_pkg::FAULT_BASE_CYC,
    parameter int GATE_LEN = cvt_pkg::GATE_OPEN_CYC
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic coil_valid,
    input wire logic optic_upper,
    input wire logic optic_lower,
    input wire logic acceptance_block,
    input wire logic block_active_high,
    input wire logic ref_coin_present,
    input wire logic [cvt_pkg::FAULT_SEL_W-1:0] fault_len_sel,
    output logic coil_match,
    output logic coin_accepted,
    output logic fault_alert,
    output logic accept_gate,
    output logic lamp_green,
    output logic lamp_red
);
    import cvt_pkg::*;

    typedef struct packed {
        logic [IN_W-1:0] sync1;
        logic [IN_W-1:0] sync2;
        logic coil_prev;
        cvt_opt_t opt;
        logic [CNT_W-1:0] dwell_cnt;
        logic dwell_fired;
        logic [CNT_W-1:0] blk_cnt;
        logic blk_hold;
        logic [MATCH_W-1:0] match_cnt;
        logic [QUEUE_W-1:0] queue;
        logic [CNT_W-1:0] gate_cnt;
        logic coil_match;
        logic coin_accepted;
        logic fault_alert;
        logic accept_gate;
        logic lamp_green;
        logic lamp_red;
    } cvt_state_t;

    cvt_state_t s_q;
    cvt_state_t s_d;

    cvt_pulse_if match_if ();
    cvt_pulse_if credit_if ();
    cvt_pulse_if fault_if ();

    cvt_pulse_gen u_match (.core_clk(core_clk), .rst(rst), .pif(match_if.gen));
    cvt_pulse_gen u_credit (.core_clk(core_clk), .rst(rst), .pif(credit_if.gen));
    cvt_pulse_gen u_fault (.core_clk(core_clk), .rst(rst), .pif(fault_if.gen));

    logic coil_s;
    logic upper_s;
    logic lower_s;
    logic blocked;
    logic coil_rise;
    logic fault_ev;
    logic fault_now;
    logic enabled;
    logic passage;
    logic reverse;
    logic credit_start;
    logic [FAULT_SEL_W-1:0] sel_s;

    // ------------------------------------------------------------
    // synchronised inputs and decoded conditions
    // ------------------------------------------------------------
    assign coil_s = s_q.sync2[IN_COIL];
    assign upper_s = s_q.sync2[IN_UPPER];
    assign lower_s = s_q.sync2[IN_LOWER];
    assign sel_s = s_q.sync2[IN_SEL +: FAULT_SEL_W];
    assign blocked = s_q.sync2[IN_BLOCK] == s_q.sync2[IN_POL];
    assign coil_rise = coil_s & ~s_q.coil_prev;
    assign reverse = (s_q.opt == OPT_IDLE) & lower_s & ~upper_s;
    assign passage = (s_q.opt == OPT_LOWER) & ~lower_s & ~upper_s;
    assign credit_start = (s_q.queue != '0) & ~credit_if.busy;

    // ------------------------------------------------------------
    // pulse generator requests
    // ------------------------------------------------------------
    assign match_if.start = coil_rise;
    assign match_if.high_len = CNT_W'(MATCH_LEN);
    assign match_if.low_len = '0;
    assign credit_if.start = credit_start;
    assign credit_if.high_len = CNT_W'(CREDIT_LEN);
    assign credit_if.low_len = CNT_W'(CREDIT_GAP);
    assign fault_if.high_len = CNT_W'(FAULT_BASE) << sel_s;
    assign fault_if.low_len = '0;
    assign fault_if.start = fault_ev;

    always_comb begin
        s_d = s_q;
        fault_ev = 1'b0;
        s_d.sync1 = {fault_len_sel, ref_coin_present, block_active_high,
                     acceptance_block, optic_lower, optic_upper, coil_valid};
        s_d.sync2 = s_q.sync1;
        s_d.coil_prev = coil_s;

        // --------------------------------------------------------
        // coil dwell supervision
        // --------------------------------------------------------
        if (!coil_s) begin
            s_d.dwell_cnt = '0;
            s_d.dwell_fired = 1'b0;
        end else if (s_q.dwell_cnt < CNT_W'(DWELL_CYC)) begin
            s_d.dwell_cnt = s_q.dwell_cnt + 1'b1;
        end else if (!s_q.dwell_fired) begin
            s_d.dwell_fired = 1'b1;
            fault_ev = 1'b1;
        end

        // --------------------------------------------------------
        // blocked optic hold
        // --------------------------------------------------------
        if (!upper_s && !lower_s) begin
            s_d.blk_cnt = '0;
            s_d.blk_hold = 1'b0;
        end else if (s_q.blk_cnt < CNT_W'(BLOCK_CYC) - 1'b1) begin
            s_d.blk_cnt = s_q.blk_cnt + 1'b1;
        end else begin
            s_d.blk_hold = 1'b1;
        end

        // --------------------------------------------------------
        // optic passage sequence
        // --------------------------------------------------------
        case (s_q.opt)
            OPT_IDLE: begin
                if (upper_s && !lower_s) begin
                    s_d.opt = OPT_UPPER;
                end else if (lower_s) begin
                    fault_ev = 1'b1;
                end
            end
            OPT_UPPER: begin
                if (lower_s) begin
                    s_d.opt = OPT_BOTH;
                end else if (!upper_s) begin
                    s_d.opt = OPT_IDLE;
                end
            end
            OPT_BOTH: begin
                if (!upper_s) begin
                    s_d.opt = OPT_LOWER;
                end else if (!lower_s) begin
                    s_d.opt = OPT_UPPER;
                    fault_ev = 1'b1;
                end
            end
            OPT_LOWER: begin
                if (upper_s) begin
                    s_d.opt = OPT_BOTH;
                    fault_ev = 1'b1;
                end else if (!lower_s) begin
                    s_d.opt = OPT_IDLE;
                end
            end
            default: begin
                s_d.opt = OPT_IDLE;
            end
        endcase

        fault_now = fault_if.pulse | s_q.blk_hold;
        enabled = ~blocked & ~fault_now & s_q.sync2[IN_REF];

        // --------------------------------------------------------
        // gate, match pairing and credit queue
        // --------------------------------------------------------
        if (!enabled) begin
            s_d.gate_cnt = '0;
        end else if (coil_rise) begin
            s_d.gate_cnt = CNT_W'(GATE_LEN);
        end else if (s_q.gate_cnt != '0) begin
            s_d.gate_cnt = s_q.gate_cnt - 1'b1;
        end

        if (coil_rise && enabled && s_q.match_cnt != MATCH_MAX) begin
            s_d.match_cnt = s_q.match_cnt + 1'b1;
        end
        if (passage) begin
            if (s_d.match_cnt != '0) begin
                s_d.match_cnt = s_d.match_cnt - 1'b1;
                if (s_q.queue != QUEUE_MAX) begin
                    s_d.queue = s_q.queue + 1'b1;
                end
            end else begin
                fault_ev = 1'b1;
            end
        end
        if (credit_start) begin
            s_d.queue = s_d.queue - 1'b1;
        end

        // --------------------------------------------------------
        // registered outputs
        // --------------------------------------------------------
        s_d.coil_match = match_if.pulse;
        s_d.coin_accepted = credit_if.pulse;
        s_d.fault_alert = fault_now;
        s_d.accept_gate = s_d.gate_cnt != '0;
        s_d.lamp_red = ~enabled;
        s_d.lamp_green = enabled;
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign coil_match = s_q.coil_match;
    assign coin_accepted = s_q.coin_accepted;
    assign fault_alert = s_q.fault_alert;
    assign accept_gate = s_q.accept_gate;
    assign lamp_green = s_q.lamp_green;
    assign lamp_red = s_q.lamp_red;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_block_gate_shut: assert property (@(posedge core_clk) disable iff (rst)
        blocked |=> !accept_gate && lamp_red)
        else $error("gate open while acceptance blocked");

    a_dwell_fault: assert property (@(posedge core_clk) disable iff (rst)
        (coil_s && s_q.dwell_cnt == CNT_W'(DWELL_CYC) && !s_q.dwell_fired
         && !fault_if.busy) |-> ##2 fault_alert)
        else $error("long coil dwell gave no fault");

    a_hold_blocked: assert property (@(posedge core_clk) disable iff (rst)
        (s_q.blk_hold && (upper_s || lower_s)) |=> fault_alert)
        else $error("fault dropped while optic still blocked");

    a_reverse_fault: assert property (@(posedge core_clk) disable iff (rst)
        (reverse && !fault_if.busy) |-> ##2 fault_alert)
        else $error("reverse travel gave no fault");

    a_unmatched_fault: assert property (@(posedge core_clk) disable iff (rst)
        (passage && s_q.match_cnt == '0 && !(coil_rise && enabled) && !fault_if.busy)
        |-> ##2 fault_alert)
        else $error("unmatched passage gave no fault");

    a_fault_gate_shut: assert property (@(posedge core_clk) disable iff (rst)
        fault_alert |-> !accept_gate)
        else $error("gate open during fault");

    a_credit_paired: assert property (@(posedge core_clk) disable iff (rst)
        $rose(coin_accepted) |-> $past(s_q.queue, 2) != '0)
        else $error("credit without queued coin");

    a_match_pulse: assert property (@(posedge core_clk) disable iff (rst)
        (coil_rise && !match_if.busy) |-> ##2 coil_match)
        else $error("coil detection gave no match pulse");

    a_lamp_colours: assert property (@(posedge core_clk) disable iff (rst)
        !$past(rst) |-> lamp_green != lamp_red)
        else $error("lamp both or neither colour");

    a_red_refuse: assert property (@(posedge core_clk) disable iff (rst)
        lamp_red |-> !accept_gate && !$rose(accept_gate))
        else $error("coin accepted while lamp red");

    a_gate_opens: assert property (@(posedge core_clk) disable iff (rst)
        (coil_rise && enabled) |=> accept_gate)
        else $error("enabled coil match left gate shut");

    a_passage_queued: assert property (@(posedge core_clk) disable iff (rst)
        (passage && s_q.match_cnt != '0 && s_q.queue != QUEUE_MAX && !credit_start)
        |=> s_q.queue == $past(s_q.queue) + 1'b1)
        else $error("paired passage not queued");

    a_backout_fault: assert property (@(posedge core_clk) disable iff (rst)
        (s_q.opt == OPT_BOTH && upper_s && !lower_s && !fault_if.busy) |-> ##2 fault_alert)
        else $error("coin backing out gave no fault");

    a_noref_red: assert property (@(posedge core_clk) disable iff (rst)
        !s_q.sync2[IN_REF] |=> lamp_red)
        else $error("lamp not red without reference coin");
endmodule

/* cvt_host_model.sv */
`timescale 1ns/1ps
// ------------------------------------------------------------
// host side: counts pulses and measures widths and gaps
// ------------------------------------------------------------
module cvt_host_model (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic coil_match,
    input wire logic coin_accepted,
    input wire logic fault_alert,
    output int match_cnt,
    output int credit_cnt,
    output int fault_cnt,
    output int credit_w,
    output int credit_gap,
    output int fault_w
);
    logic m_q, c_q, f_q;
    int cw, cg, fw;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            {m_q, c_q, f_q} <= 3'h0;
            {match_cnt, credit_cnt, fault_cnt} <= '0;
            {credit_w, credit_gap, fault_w} <= '0;
            {cw, cg, fw} <= '0;
        end else begin
            m_q <= coil_match;
            c_q <= coin_accepted;
            f_q <= fault_alert;
            if (coil_match && !m_q) begin
                match_cnt <= match_cnt + 1;
            end
            // credit width and low gap before each credit
            if (coin_accepted) begin
                cw <= c_q ? cw + 1 : 1;
                if (!c_q) begin
                    credit_cnt <= credit_cnt + 1;
                    credit_gap <= cg;
                end
            end else begin
                cg <= c_q ? 1 : cg + 1;
                if (c_q) begin
                    credit_w <= cw;
                end
            end
            // fault pulse width
            if (fault_alert) begin
                fw <= f_q ? fw + 1 : 1;
                if (!f_q) begin
                    fault_cnt <= fault_cnt + 1;
                end
            end else if (f_q) begin
                fault_w <= fw;
            end
        end
    end
endmodule

/* tb_top.sv */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin err_count++; \
    $display("wrong value %s expected %0d seen %0d", nm, e, g); end end
module tb_top;
    import cvt_pkg::*;
    localparam int FBASE = 8;
    localparam int PLEN = 4;
    logic core_clk, rst, coil_valid, optic_upper, optic_lower;
    logic acceptance_block, block_active_high, ref_coin_present;
    logic [FAULT_SEL_W-1:0] fault_len_sel;
    logic coil_match, coin_accepted, fault_alert, accept_gate, lamp_green, lamp_red;
    int match_cnt, credit_cnt, fault_cnt, credit_w, credit_gap, fault_w;
    int err_count, checks, cycles, f0, c0, m0;

    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    cvt_coin_validator #(.DWELL_CYC(50), .BLOCK_CYC(100), .MATCH_LEN(PLEN), .CREDIT_LEN(PLEN),
        .CREDIT_GAP(PLEN), .FAULT_BASE(FBASE), .GATE_LEN(20)) u_cvt_coin_validator (
        .core_clk(core_clk), .rst(rst), .coil_valid(coil_valid),
        .optic_upper(optic_upper), .optic_lower(optic_lower),
        .acceptance_block(acceptance_block), .block_active_high(block_active_high),
        .ref_coin_present(ref_coin_present), .fault_len_sel(fault_len_sel),
        .coil_match(coil_match), .coin_accepted(coin_accepted), .fault_alert(fault_alert),
        .accept_gate(accept_gate), .lamp_green(lamp_green), .lamp_red(lamp_red));

    cvt_host_model u_cvt_host_model (
        .core_clk(core_clk), .rst(rst), .coil_match(coil_match),
        .coin_accepted(coin_accepted), .fault_alert(fault_alert),
        .match_cnt(match_cnt), .credit_cnt(credit_cnt), .fault_cnt(fault_cnt),
        .credit_w(credit_w), .credit_gap(credit_gap), .fault_w(fault_w));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask

    task automatic opt_pass(input int st);
        optic_upper = 1'b1;
        cyc(st);
        optic_lower = 1'b1;
        cyc(st);
        optic_upper = 1'b0;
        cyc(st);
        optic_lower = 1'b0;
        cyc(st);
    endtask

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_fault_len;
        for (int s = 0; s < 4; s++) begin
            f0 = fault_cnt;
            fault_len_sel = s[FAULT_SEL_W-1:0];
            cyc(4);
            opt_pass(2);
            for (int i = 0; i < 20 && fault_alert !== 1'b1; i++) cyc(1);
            `CHK("lamp_red", 1, lamp_red)
            `CHK("gate", 0, accept_gate)
            cyc(80);
            `CHK("fault_cnt", f0 + 1, fault_cnt)
            `CHK("fault_w", FBASE << s, fault_w)
        end
        fault_len_sel = '0;
        $display("test fault_len done");
    endtask

    task automatic t_reverse;
        f0 = fault_cnt;
        optic_lower = 1'b1;
        cyc(3);
        optic_lower = 1'b0;
        cyc(20);
        `CHK("fault_cnt", f0 + 1, fault_cnt)
        $display("test reverse done");
    endtask

    task automatic t_backout;
        f0 = fault_cnt;
        optic_upper = 1'b1;
        cyc(3);
        optic_lower = 1'b1;
        cyc(3);
        optic_lower = 1'b0;
        cyc(3);
        optic_upper = 1'b0;
        cyc(20);
        `CHK("fault_cnt", f0 + 1, fault_cnt)
        `CHK("fault_w", FBASE, fault_w)
        $display("test backout done");
    endtask

    task automatic t_coin;
        {f0, c0, m0} = {fault_cnt, credit_cnt, match_cnt};
        coil_valid = 1'b1;
        cyc(6);
        `CHK("gate", 1, accept_gate)
        coil_valid = 1'b0;
        cyc(4);
        opt_pass(2);
        cyc(20);
        `CHK("match_cnt", m0 + 1, match_cnt)
        `CHK("credit_cnt", c0 + 1, credit_cnt)
        `CHK("credit_w", PLEN, credit_w)
        `CHK("fault_cnt", f0, fault_cnt)
        $display("test coin done");
    endtask

    task automatic t_queue;
        {f0, c0} = {fault_cnt, credit_cnt};
        repeat (2) begin
            coil_valid = 1'b1;
            cyc(3);
            coil_valid = 1'b0;
            cyc(8);
        end
        opt_pass(1);
        cyc(1);
        opt_pass(1);
        cyc(40);
        `CHK("credit_cnt", c0 + 2, credit_cnt)
        `CHK("credit_w", PLEN, credit_w)
        `CHK("gap_ok", 1, int'(credit_gap >= PLEN))
        `CHK("fault_cnt", f0, fault_cnt)
        $display("test queue done");
    endtask

    task automatic t_inhibit;
        for (int p = 0; p < 2; p++) begin
            block_active_high = p[0];
            acceptance_block = p[0];
            cyc(5);
            `CHK("lamp_red", 1, lamp_red)
            `CHK("lamp_green", 0, lamp_green)
            coil_valid = 1'b1;
            cyc(6);
            `CHK("gate", 0, accept_gate)
            coil_valid = 1'b0;
            acceptance_block = ~p[0];
            cyc(5);
            `CHK("lamp_green", 1, lamp_green)
        end
        $display("test inhibit done");
    endtask

    task automatic t_noref;
        ref_coin_present = 1'b0;
        cyc(5);
        `CHK("lamp_red", 1, lamp_red)
        coil_valid = 1'b1;
        cyc(6);
        `CHK("gate", 0, accept_gate)
        coil_valid = 1'b0;
        ref_coin_present = 1'b1;
        cyc(5);
        `CHK("lamp_green", 1, lamp_green)
        $display("test noref done");
    endtask

    task automatic t_hold;
        optic_upper = 1'b1;
        cyc(115);
        `CHK("fault", 1, fault_alert)
        coil_valid = 1'b1;
        cyc(6);
        `CHK("gate", 0, accept_gate)
        coil_valid = 1'b0;
        cyc(30);
        `CHK("fault", 1, fault_alert)
        `CHK("lamp_red", 1, lamp_red)
        optic_upper = 1'b0;
        cyc(6);
        `CHK("fault", 0, fault_alert)
        $display("test hold done");
    endtask

    task automatic t_dwell;
        f0 = fault_cnt;
        coil_valid = 1'b1;
        cyc(40);
        `CHK("fault", 0, fault_alert)
        cyc(30);
        coil_valid = 1'b0;
        cyc(10);
        `CHK("fault_cnt", f0 + 1, fault_cnt)
        $display("test dwell done");
    endtask

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 4000) begin
            err_count++;
            print_verdict();
        end
    end

    initial begin
        {err_count, checks, cycles} = '0;
        {rst, coil_valid, optic_upper, optic_lower, acceptance_block} = 5'h10;
        {block_active_high, ref_coin_present} = 2'h3;
        fault_len_sel = '0;
        cyc(10);
        rst = 1'b0;
        cyc(6);
        `CHK("lamp_green", 1, lamp_green)
        `CHK("lamp_red", 0, lamp_red)
        t_fault_len();
        t_reverse();
        t_backout();
        t_coin();
        t_queue();
        t_inhibit();
        t_noref();
        t_hold();
        t_dwell();
        print_verdict();
    end
endmodule
